// ===== design/pdm_pkg.sv
// package: constants and types of the power-down mode controller
package pdm_pkg;
  // standby control register, byte address and layout
  localparam logic [15:0] STBY_CTRL_ADDR = 16'hfffb;
  localparam logic [7:0] STBY_CTRL_RESET = 8'h7f;
  localparam int STBY_SEL_POS = 7;
  localparam logic [6:0] STBY_RSVD_ONES = 7'h7f;
  // mode pin codes
  localparam logic [2:0] MODE_HW_STANDBY = 3'h6;
  localparam logic [2:0] MODE_PROGRAMMING = 3'h0;
  localparam logic [2:0] MODE_RUN_DEFAULT = 3'h7;
  // watchdog settling counter
  localparam logic [7:0] WDOG_START = 8'h00;
  localparam logic [7:0] WDOG_LAST = 8'hff;
  localparam logic [2:0] WDOG_CKS_MIN = 3'h0;
  // timing at 20 MHz
  localparam int CLK_PERIOD_NS = 50;
  localparam int XTAL_SETTLE_MS = 10;
  localparam int XTAL_SETTLE_CYC = (XTAL_SETTLE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYC = 4;
  // host register offsets on apb
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_MODE_OFS = 8'h04;
  localparam logic [7:0] HOST_STAT_OFS = 8'h08;
  localparam logic [7:0] HOST_SETTLE_OFS = 8'h0c;
  // host command codes
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_ENTER_HWSTBY = 2'h1;
  localparam logic [1:0] CMD_LEAVE_HWSTBY = 2'h2;
  localparam logic [1:0] CMD_PULSE_RESET = 2'h3;
  // device power states, one-hot
  typedef enum logic [5:0] {
    PDM_RESET = 6'b000001,
    PDM_RUN = 6'b000010,
    PDM_SLEEP = 6'b000100,
    PDM_SWSTBY = 6'b001000,
    PDM_SETTLE = 6'b010000,
    PDM_HWSTBY = 6'b100000
  } pdm_state_t;
  // host sequencer states, one-hot
  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_ENTER_RST = 5'b00010,
    HS_IN_HW = 5'b00100,
    HS_WAIT_CLK = 5'b01000,
    HS_PULSE = 5'b10000
  } pdm_host_state_t;
endpackage

// ===== design/pdm_link_if.sv
// interface: pins between device and external system logic
`timescale 1ns/1ps
interface pdm_link_if;
  logic chipClearPinN; // reset pin, active low
  logic [2:0] modeSelectPins; // mode pins, upper bit first
  modport device (input chipClearPinN, input modeSelectPins);
  modport host (output chipClearPinN, output modeSelectPins);
endinterface

// ===== design/pdm_settle_counter.sv
// module: oscillator settling counter of the watchdog
`timescale 1ns/1ps
module pdm_settle_counter #(
  parameter int PRESCALE_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] watchdogClockSelect,
  output logic overflow
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PRESCALE_W-1:0] pre; // prescaler
    logic [7:0] count; // settling count
    logic ovf; // overflow pulse
  } pdm_cnt_t;
  pdm_cnt_t cur;
  pdm_cnt_t next_cur;
  logic tick;
  // tick each 2^(cks+1) clocks
  always_comb begin
    logic [PRESCALE_W-1:0] mask;
    // widened before the add so the slowest rate does not wrap to zero
    mask = (PRESCALE_W)'((1 << ({1'b0, watchdogClockSelect} + 4'h1)) - 1);
    tick = (cur.pre & mask) == mask;
  end
  // count from zero, overflow past last
  always_comb begin
    next_cur = cur;
    next_cur.ovf = 1'b0;
    if (!run) begin
      next_cur.pre = '0;
      next_cur.count = pdm_pkg::WDOG_START;
    end else begin
      next_cur.pre = cur.pre + 1'b1;
      if (tick) begin
        next_cur.count = cur.count + 8'h01;
        next_cur.ovf = cur.count == pdm_pkg::WDOG_LAST;
      end
    end
  end
  // register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  assign overflow = cur.ovf;
endmodule

// ===== design/pdm_device.sv
// module: power-down mode control, device end
`timescale 1ns/1ps
module pdm_device (
  input wire logic sys_clk,
  input wire logic rst_n,
  pdm_link_if.device link,
  input wire logic haltExec,
  input wire logic irqRequest,
  input wire logic [2:0] irqLevel,
  input wire logic irqSourceEnable,
  input wire logic [2:0] cpuMaskLevel,
  input wire logic irqToTransfer,
  input wire logic transferDone,
  input wire logic [15:0] transferCountRegister,
  input wire logic nmiPin,
  input wire logic watchdogRunEnable,
  input wire logic [2:0] watchdogClockSelect,
  input wire logic regWrite,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic cpuRun,
  output logic clockRun,
  output logic peripheralRun,
  output logic peripheralInit,
  output logic cpuRegsHeld,
  output logic portsFloat,
  output logic irqServiceStart,
  output logic transferStart,
  output logic nmiServiceStart,
  output logic resetSequence,
  output logic [5:0] powerState
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    pdm_pkg::pdm_state_t st; // power state
    logic standbySelect; // bit 7 of control register
    logic waitTransfer; // sleeping wake served by transfer
    logic [7:0] rdata; // register read data
    logic cpuRun;
    logic clockRun;
    logic periphRun;
    logic periphInit;
    logic regsHeld;
    logic portsFloat;
    logic irqStart;
    logic xferStart;
    logic nmiStart;
    logic rstSeq;
    logic nmiPrev; // previous nmi level
  } pdm_dev_t;
  pdm_dev_t cur;
  pdm_dev_t next_cur;
  logic settleOvf; // settling count overflow
  logic hwCode; // mode pins show hardware standby
  logic irqWake; // interrupt allowed to wake
  logic nmiEdge;
  // ---------------------------------------------------------------
  // settling counter
  // ---------------------------------------------------------------
  pdm_settle_counter #(.PRESCALE_W(12)) u_settle (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(cur.st == pdm_pkg::PDM_SETTLE),
    .watchdogClockSelect(watchdogClockSelect),
    .overflow(settleOvf)
  );
  // ---------------------------------------------------------------
  // wake decode
  // ---------------------------------------------------------------
  always_comb begin
    hwCode = link.modeSelectPins == pdm_pkg::MODE_HW_STANDBY;
    // masked or disabled requests never wake
    irqWake = irqRequest && irqSourceEnable
      && (irqLevel > cpuMaskLevel);
    nmiEdge = nmiPin && !cur.nmiPrev;
  end
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.irqStart = 1'b0;
    next_cur.xferStart = 1'b0;
    next_cur.nmiStart = 1'b0;
    next_cur.rstSeq = 1'b0;
    next_cur.nmiPrev = nmiPin; // edge detector history
    // control register write, select cannot be set to one while watchdog runs
    if (regWrite && regAddr == pdm_pkg::STBY_CTRL_ADDR) begin
      if (!(watchdogRunEnable && regWdata[pdm_pkg::STBY_SEL_POS])) begin
        next_cur.standbySelect = regWdata[pdm_pkg::STBY_SEL_POS];
      end
    end
    // control register read view
    next_cur.rdata = {cur.standbySelect, pdm_pkg::STBY_RSVD_ONES};
    case (cur.st)
      pdm_pkg::PDM_RESET: begin
        next_cur.standbySelect = 1'b0;
        if (link.chipClearPinN) begin
          next_cur.st = pdm_pkg::PDM_RUN;
          next_cur.rstSeq = 1'b1;
        end
      end
      pdm_pkg::PDM_RUN: begin
        if (haltExec) begin
          next_cur.st = cur.standbySelect ? pdm_pkg::PDM_SWSTBY
            : pdm_pkg::PDM_SLEEP;
        end
      end
      pdm_pkg::PDM_SLEEP: begin
        if (cur.waitTransfer) begin
          // resume after transfer unless count exhausted
          if (transferDone && transferCountRegister != 16'h0000) begin
            next_cur.waitTransfer = 1'b0;
            next_cur.st = pdm_pkg::PDM_RUN;
          end
        end else if (irqWake) begin
          if (irqToTransfer) begin
            next_cur.xferStart = 1'b1;
            next_cur.waitTransfer = 1'b1;
          end else begin
            next_cur.irqStart = 1'b1;
            next_cur.st = pdm_pkg::PDM_RUN;
          end
        end
      end
      pdm_pkg::PDM_SWSTBY: begin
        if (nmiEdge) begin
          next_cur.st = pdm_pkg::PDM_SETTLE;
        end
      end
      pdm_pkg::PDM_SETTLE: begin
        if (settleOvf) begin
          next_cur.st = pdm_pkg::PDM_RUN;
          next_cur.nmiStart = 1'b1;
          next_cur.standbySelect = 1'b0;
        end
      end
      pdm_pkg::PDM_HWSTBY: begin
        next_cur.standbySelect = 1'b0;
        if (!hwCode && !link.chipClearPinN) begin
          next_cur.st = pdm_pkg::PDM_RESET;
        end
      end
      default: begin
        next_cur.st = pdm_pkg::PDM_RESET;
      end
    endcase
    // reset pin low: reset from any state but hardware standby
    if (!link.chipClearPinN && cur.st != pdm_pkg::PDM_HWSTBY) begin
      next_cur.st = pdm_pkg::PDM_RESET;
      next_cur.waitTransfer = 1'b0;
    end
    // mode code six overrides everything
    if (hwCode) begin
      next_cur.st = pdm_pkg::PDM_HWSTBY;
      next_cur.standbySelect = 1'b0;
      next_cur.waitTransfer = 1'b0;
    end
    // status outputs from next state
    next_cur.cpuRun = next_cur.st == pdm_pkg::PDM_RUN;
    next_cur.clockRun = !(next_cur.st inside {pdm_pkg::PDM_SWSTBY,
      pdm_pkg::PDM_SETTLE, pdm_pkg::PDM_HWSTBY});
    next_cur.periphRun = next_cur.st inside {pdm_pkg::PDM_RUN,
      pdm_pkg::PDM_SLEEP};
    next_cur.periphInit = next_cur.st inside {pdm_pkg::PDM_SWSTBY,
      pdm_pkg::PDM_SETTLE, pdm_pkg::PDM_HWSTBY,
      pdm_pkg::PDM_RESET};
    next_cur.regsHeld = next_cur.st != pdm_pkg::PDM_HWSTBY;
    next_cur.portsFloat = next_cur.st == pdm_pkg::PDM_HWSTBY;
  end
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur <= '0;
      cur.st <= pdm_pkg::PDM_RESET;
      cur.rdata <= pdm_pkg::STBY_CTRL_RESET;
      cur.periphInit <= 1'b1;
      cur.clockRun <= 1'b1;
      cur.regsHeld <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end
  // outputs straight from flops
  assign regRdata = cur.rdata;
  assign cpuRun = cur.cpuRun;
  assign clockRun = cur.clockRun;
  assign peripheralRun = cur.periphRun;
  assign peripheralInit = cur.periphInit;
  assign cpuRegsHeld = cur.regsHeld;
  assign portsFloat = cur.portsFloat;
  assign irqServiceStart = cur.irqStart;
  assign transferStart = cur.xferStart;
  assign nmiServiceStart = cur.nmiStart;
  assign resetSequence = cur.rstSeq;
  assign powerState = cur.st;
endmodule

// ===== design/pdm_host.sv
// module: external system logic driving mode and reset pins
`timescale 1ns/1ps
module pdm_host #(
  parameter int SETTLE_CYC = pdm_pkg::XTAL_SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  pdm_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    pdm_pkg::pdm_host_state_t st;
    logic [2:0] runMode; // mode applied on recovery
    logic [2:0] pins; // mode pins driven
    logic clearN; // reset pin driven
    logic [31:0] settle; // settling wait length
    logic [31:0] cnt; // wait counter
    logic [31:0] rdata;
    logic ready;
    logic err;
  } pdm_host_s_t;
  pdm_host_s_t cur;
  pdm_host_s_t next_cur;
  logic access;
  logic [1:0] cmd;
  always_comb begin
    access = psel && penable && !cur.ready;
    cmd = pwdata[1:0];
  end
  // ---------------------------------------------------------------
  // sequencer and apb slave
  // ---------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.ready = access;
    next_cur.err = 1'b0;
    if (cur.cnt != 32'h0) begin
      next_cur.cnt = cur.cnt - 32'h1;
    end
    if (access) begin
      next_cur.err = !(paddr inside {pdm_pkg::HOST_CMD_OFS,
        pdm_pkg::HOST_MODE_OFS, pdm_pkg::HOST_STAT_OFS,
        pdm_pkg::HOST_SETTLE_OFS});
      case (paddr)
        pdm_pkg::HOST_MODE_OFS: next_cur.rdata = {29'h0, cur.runMode};
        pdm_pkg::HOST_STAT_OFS: next_cur.rdata = {23'h0, cur.clearN,
          cur.pins, cur.st};
        pdm_pkg::HOST_SETTLE_OFS: next_cur.rdata = cur.settle;
        default: next_cur.rdata = 32'h0;
      endcase
      if (pwrite && paddr == pdm_pkg::HOST_MODE_OFS) begin
        // never programming code nor standby code as run mode
        if (!(pwdata[2:0] inside {pdm_pkg::MODE_PROGRAMMING,
            pdm_pkg::MODE_HW_STANDBY, 3'h5})) begin
          next_cur.runMode = pwdata[2:0];
        end
      end
      if (pwrite && paddr == pdm_pkg::HOST_SETTLE_OFS) begin
        next_cur.settle = pwdata;
      end
    end
    case (cur.st)
      pdm_pkg::HS_IDLE: begin
        if (access && pwrite && paddr == pdm_pkg::HOST_CMD_OFS) begin
          if (cmd == pdm_pkg::CMD_ENTER_HWSTBY) begin
            next_cur.clearN = 1'b0;
            next_cur.cnt = 32'(pdm_pkg::RESET_HOLD_CYC);
            next_cur.st = pdm_pkg::HS_ENTER_RST;
          end else if (cmd == pdm_pkg::CMD_PULSE_RESET) begin
            next_cur.clearN = 1'b0;
            next_cur.cnt = cur.settle;
            next_cur.st = pdm_pkg::HS_PULSE;
          end
        end
      end
      pdm_pkg::HS_ENTER_RST: begin
        if (cur.cnt == 32'h0) begin
          next_cur.pins = pdm_pkg::MODE_HW_STANDBY;
          next_cur.st = pdm_pkg::HS_IN_HW;
        end
      end
      pdm_pkg::HS_IN_HW: begin
        // pins held steady until told to leave
        if (access && pwrite && paddr == pdm_pkg::HOST_CMD_OFS
            && cmd == pdm_pkg::CMD_LEAVE_HWSTBY) begin
          next_cur.pins = cur.runMode;
          next_cur.cnt = cur.settle;
          next_cur.st = pdm_pkg::HS_WAIT_CLK;
        end
      end
      pdm_pkg::HS_WAIT_CLK, pdm_pkg::HS_PULSE: begin
        if (cur.cnt == 32'h0) begin
          next_cur.clearN = 1'b1;
          next_cur.st = pdm_pkg::HS_IDLE;
        end
      end
      default: begin
        next_cur.st = pdm_pkg::HS_IDLE;
      end
    endcase
  end
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur <= '0;
      cur.st <= pdm_pkg::HS_IDLE;
      cur.runMode <= pdm_pkg::MODE_RUN_DEFAULT;
      cur.pins <= pdm_pkg::MODE_RUN_DEFAULT;
      cur.clearN <= 1'b1;
      cur.settle <= SETTLE_CYC;
    end else begin
      cur <= next_cur;
    end
  end
  assign link.modeSelectPins = cur.pins;
  assign link.chipClearPinN = cur.clearN;
  assign prdata = cur.rdata;
  assign pready = cur.ready;
  assign pslverr = cur.err;
endmodule

// ===== dv/pdm_link_sva.sv
// checker: timing relations on the device and system-logic pins
`timescale 1ns/1ps
module pdm_link_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic chipClearPinN,
  input wire logic [2:0] modeSelectPins,
  input wire logic [5:0] powerState,
  input wire logic portsFloat,
  input wire logic resetSequence,
  input wire logic [7:0] regRdata
);
  // one clock domain, reset masks every check
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // device side
  // ----------------------------------------
  chk_hw_forced: assert property (modeSelectPins == 3'h6 |=>
    powerState == pdm_pkg::PDM_HWSTBY) else $error("code six not obeyed");
  chk_hw_float: assert property (powerState == pdm_pkg::PDM_HWSTBY |->
    portsFloat) else $error("ports driven in hardware standby");
  chk_clear_resets: assert property (!chipClearPinN &&
    modeSelectPins != 3'h6 |=> powerState == pdm_pkg::PDM_RESET)
    else $error("low clear pin did not reset");
  chk_release_seq: assert property ($rose(chipClearPinN) &&
    modeSelectPins != 3'h6 |-> ##[1:3] resetSequence)
    else $error("no reset sequence after release");
  chk_rsvd_ones: assert property (regRdata[6:0] == 7'h7f)
    else $error("reserved bits not all one");
  chk_hw_sel_clear: assert property ($past(powerState) ==
    pdm_pkg::PDM_HWSTBY && powerState == pdm_pkg::PDM_HWSTBY |->
    !regRdata[7]) else $error("select bit kept in hardware standby");
  // ----------------------------------------
  // system logic side
  // ----------------------------------------
  chk_entry_order: assert property ($changed(modeSelectPins) &&
    modeSelectPins == 3'h6 |-> !chipClearPinN)
    else $error("code six applied with clear pin high");
  chk_no_prog: assert property (modeSelectPins != 3'h0)
    else $error("programming code on mode pins");
  chk_settle_low: assert property ($fell(modeSelectPins == 3'h6) |->
    (!chipClearPinN) [*8]) else $error("clear pin released too soon");
  chk_enter_gap: assert property ($fell(chipClearPinN) |->
    (modeSelectPins != 3'h6) [*4]) else $error("code six too soon");
endmodule

// ===== dv/power_down_mode_control_tb_top.sv
// testbench: both ends joined, apb and device-side sequences
`timescale 1ns/1ps
module power_down_mode_control_tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic sys_clk = 1'b0, rst_n = 1'b0, haltExec = 1'b0, irqRequest = 1'b0;
  logic irqSourceEnable = 1'b0, irqToTransfer = 1'b0, transferDone = 1'b0;
  logic nmiPin = 1'b0, watchdogRunEnable = 1'b0, regWrite = 1'b0;
  logic [2:0] irqLevel = 3'h0, cpuMaskLevel = 3'h0, watchdogClockSelect = 3'h0;
  logic [15:0] transferCountRegister = 16'h0000, regAddr = 16'h0000;
  logic [7:0] regWdata = 8'h00, regRdata, paddr = 8'h00;
  logic cpuRun, clockRun, peripheralRun, peripheralInit, cpuRegsHeld;
  logic portsFloat, irqServiceStart, transferStart, nmiServiceStart;
  logic resetSequence, pready, pslverr, err;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [5:0] powerState;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] modes[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7}; // exit codes
  int fail_count = 0, n_tests = 0, cyc = 0, p, c;
  int pc[4] = '{0, 0, 0, 0}; // pulse tallies
  localparam logic [15:0] ADR = pdm_pkg::STBY_CTRL_ADDR;
  pdm_link_if link ();
  pdm_device u_pdm_device (.sys_clk, .rst_n, .link(link.device), .haltExec,
    .irqRequest, .irqLevel, .irqSourceEnable, .cpuMaskLevel, .irqToTransfer,
    .transferDone, .transferCountRegister, .nmiPin, .watchdogRunEnable,
    .watchdogClockSelect, .regWrite, .regAddr, .regWdata, .regRdata, .cpuRun,
    .clockRun, .peripheralRun, .peripheralInit, .cpuRegsHeld, .portsFloat,
    .irqServiceStart, .transferStart, .nmiServiceStart, .resetSequence,
    .powerState);
  pdm_host #(.SETTLE_CYC(20)) u_pdm_host (.sys_clk, .rst_n,
    .link(link.host), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  pdm_link_sva u_pdm_link_sva (.sys_clk, .rst_n,
    .chipClearPinN(link.chipClearPinN), .modeSelectPins(link.modeSelectPins),
    .powerState, .portsFloat, .resetSequence, .regRdata);
  // clock, pulse tallies and hang guard
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    pc[0] <= pc[0] + int'(irqServiceStart);
    pc[1] <= pc[1] + int'(transferStart);
    pc[2] <= pc[2] + int'(nmiServiceStart);
    pc[3] <= pc[3] + int'(resetSequence);
    if (cyc == 12000) begin
      fail_count++;
      results();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // control register write on the device side
  task automatic dwr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    tick(2);
  endtask
  // one-cycle halt (t=0) or transfer-done (t=1) strobe
  task automatic strobe(input bit t);
    @(posedge sys_clk);
    if (t) transferDone <= 1'b1;
    else haltExec <= 1'b1;
    @(posedge sys_clk);
    transferDone <= 1'b0;
    haltExec <= 1'b0;
    tick(2);
  endtask
  // bounded wait for a power state, then compare
  task automatic wstate(input logic [5:0] s, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      if (powerState === s) break;
    end
    chk(powerState, s);
  endtask
  task automatic results;
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    wstate(pdm_pkg::PDM_RUN, 20);
    chk(regRdata, 8'h7f);
    watchdogRunEnable <= 1'b1;
    dwr(ADR, 8'h80);
    chk(regRdata, 8'h7f);
    watchdogRunEnable <= 1'b0;
    dwr(16'hfffa, 8'h80);
    chk(regRdata, 8'h7f);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, pdm_pkg::HOST_SETTLE_OFS, 32'd20);
    apb(1'b0, pdm_pkg::HOST_SETTLE_OFS, 32'h0);
    chk(rd, 32'd20);
    $display("test registers done");
    // sleep, masked and disabled requests, then a real wake
    cpuMaskLevel <= 3'h3;
    irqLevel <= 3'h3;
    irqSourceEnable <= 1'b1;
    strobe(1'b0);
    chk(powerState, pdm_pkg::PDM_SLEEP);
    chk({cpuRun, clockRun, peripheralRun}, 3'b011);
    irqRequest <= 1'b1;
    tick(4);
    chk(powerState, pdm_pkg::PDM_SLEEP);
    irqLevel <= 3'h4;
    irqSourceEnable <= 1'b0;
    tick(4);
    chk(powerState, pdm_pkg::PDM_SLEEP);
    p = pc[0];
    irqSourceEnable <= 1'b1;
    wstate(pdm_pkg::PDM_RUN, 10);
    irqRequest <= 1'b0;
    tick(2);
    chk(pc[0] - p, 1);
    // transfer-served wake, nonzero then zero count
    irqToTransfer <= 1'b1;
    for (int k = 1; k >= 0; k--) begin
      transferCountRegister <= 16'(5 * k);
      strobe(1'b0);
      p = pc[1];
      irqRequest <= 1'b1;
      tick(4);
      irqRequest <= 1'b0;
      chk(pc[1] - p, 1);
      strobe(1'b1);
      tick(2);
      chk(32'(powerState == pdm_pkg::PDM_RUN), k);
    end
    irqToTransfer <= 1'b0;
    p = pc[3];
    apb(1'b1, pdm_pkg::HOST_CMD_OFS, 32'(pdm_pkg::CMD_PULSE_RESET));
    wstate(pdm_pkg::PDM_RUN, 60);
    tick(2);
    chk(pc[3] - p, 1);
    $display("test sleep done");
    // software standby left by nmi at two settle rates
    for (int k = 0; k < 2; k++) begin
      watchdogClockSelect <= 3'(k);
      dwr(ADR, 8'h80);
      chk(regRdata, 8'hff);
      strobe(1'b0);
      chk(powerState, pdm_pkg::PDM_SWSTBY);
      chk({clockRun, cpuRun, peripheralRun, peripheralInit}, 4'h1);
      p = pc[2];
      c = cyc;
      nmiPin <= 1'b1;
      wstate(pdm_pkg::PDM_RUN, 1200);
      chk(32'((cyc - c) inside {[(512 << k):(512 << k) + 20]}), 1);
      nmiPin <= 1'b0;
      tick(2);
      chk(pc[2] - p, 1);
      chk(regRdata, 8'h7f);
    end
    // software standby left through the clear pin
    dwr(ADR, 8'h80);
    strobe(1'b0);
    chk(powerState, pdm_pkg::PDM_SWSTBY);
    apb(1'b1, pdm_pkg::HOST_CMD_OFS, 32'(pdm_pkg::CMD_PULSE_RESET));
    wstate(pdm_pkg::PDM_RUN, 60);
    tick(2);
    chk(regRdata, 8'h7f);
    $display("test software standby done");
    // hardware standby entry and exit for every run code
    foreach (modes[i]) begin
      dwr(ADR, 8'h80);
      apb(1'b1, pdm_pkg::HOST_CMD_OFS, 32'(pdm_pkg::CMD_ENTER_HWSTBY));
      wstate(pdm_pkg::PDM_HWSTBY, 40);
      chk({portsFloat, cpuRun, cpuRegsHeld, clockRun}, 4'h8);
      apb(1'b0, pdm_pkg::HOST_STAT_OFS, 32'h0);
      chk(rd[8:5], 4'h6);
      apb(1'b1, pdm_pkg::HOST_MODE_OFS, 32'(modes[i]));
      apb(1'b1, pdm_pkg::HOST_MODE_OFS, 32'h0);
      p = pc[3];
      apb(1'b1, pdm_pkg::HOST_CMD_OFS, 32'(pdm_pkg::CMD_LEAVE_HWSTBY));
      wstate(pdm_pkg::PDM_RUN, 80);
      tick(2);
      chk(link.modeSelectPins, modes[i]);
      chk(pc[3] - p, 1);
      chk(regRdata, 8'h7f);
    end
    $display("test hardware standby done");
    results();
  end
endmodule
